// File: media_float_opcode_decoder.sv
/*
 media float opcode decoder: takes instruction bytes from fetch one at a time after the
 leading 0F escape, walks modrm, sib and displacement, and issues micro-operations.
 assumes fetch delivers bytes in program order and that effAddr holds the operand's
 effective address from the last address byte until the memory micro-operation is taken.
*/
// Functional notes
// RULE_01 - 0F 0E issues vector media exit
// RULE_02 - suffix BF is ubyte average, short
// RULE_03 - suffix 1D float-to-dword, 0D dword-to-float
// RULE_04 - suffix 1C float-to-word, 0C word-to-float
// RULE_05 - suffixes AE, 8A, 8E are accumulates
// RULE_06 - suffixes 9E, 9A, AA add/subtract/reverse subtract
// RULE_07 - suffixes B0, 90, A0 are compares
// RULE_08 - suffix A4 maximum, 94 minimum
// RULE_09 - suffix B4 multiply, B7 multiply-high rounded
// RULE_10 - suffixes 96, A6, B6 reciprocal steps
// RULE_11 - suffix 97 inverse sqrt, A7 refine
// RULE_12 - suffix BB swaps dword halves
// RULE_13 - 0F 0D reg 000 is vector load hint; the code issues it as a UOP_LOAD, not as UOP_VECTOR
// RULE_14 - reg 001 write hint behaves as plain hint
// RULE_15 - hint address selects its 32-byte line
// RULE_16 - register form meu; memory form mload, meu
// RULE_17 - 0F 0F escapes into packed-float space
// RULE_18 - suffix opcode follows modrm and address bytes
// RULE_19 - unknown suffix flagged invalid, never issued
`default_nettype none
module media_float_opcode_decoder (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   byteValid,
   input  wire logic [7:0]             byteData,
   output logic                        byteReady,
   input  wire logic [31:0]            effAddr,
   output logic                        uopValid,
   input  wire logic                   uopReady,
   output mfod_pkg::mfod_uop_type      uopKind,
   output mfod_pkg::mfod_op_type       uopOp,
   output logic [31:0]                 uopAddr,
   output logic [7:0]                  uopModrm,
   output logic                        invalidOpcode,
   output logic                        notMedia
);
   typedef struct packed {
      mfod_pkg::mfod_state_type st;
      logic                     twoByte;
      logic [7:0]               modrm;
      logic [2:0]               dispLeft;
      logic                     uopValid;
      mfod_pkg::mfod_uop_type   uopKind;
      mfod_pkg::mfod_op_type    uopOp;
      logic [31:0]              uopAddr;
      logic                     invalid;
      logic                     notMedia;
   } mfod_regs_type;

   mfod_regs_type s_reg;
   mfod_regs_type s_next;
   logic          take;
   logic          addrDone;

   mfod_lookup_if lk ();

   mfod_op_lookup u_lookup (
      .port (lk.lookup)
   );

   // displacement bytes that follow modrm when no sib byte is present
   function automatic logic [2:0] dispBytes(input logic [7:0] m);
      logic [2:0] n;
      n = mfod_pkg::RESET_DISP;
      if (m[7:6] == mfod_pkg::MOD_DISP8) begin
         n = mfod_pkg::DISP8_BYTES;
      end else if (m[7:6] == mfod_pkg::MOD_DISP32) begin
         n = mfod_pkg::DISP32_BYTES;
      end else if (m[7:6] == mfod_pkg::MOD_NODISP && m[2:0] == mfod_pkg::RM_DIRECT) begin
         n = mfod_pkg::DISP32_BYTES;
      end
      return n;
   endfunction

   // a sib with no base register and mod 00 still carries a 32-bit displacement
   function automatic logic [2:0] sibDispBytes(input logic [7:0] m, input logic [7:0] sib);
      logic [2:0] n;
      n = dispBytes(m);
      if (m[7:6] == mfod_pkg::MOD_NODISP && sib[2:0] == mfod_pkg::RM_DIRECT) begin
         n = mfod_pkg::DISP32_BYTES;
      end
      return n;
   endfunction

   function automatic logic needsSib(input logic [7:0] m);
      return (m[7:6] != mfod_pkg::MOD_REGISTER) && (m[2:0] == mfod_pkg::RM_SIB);
   endfunction

   assign lk.opcode = byteData;
   assign take      = byteValid && byteReady;

   always_comb begin
      s_next          = s_reg;
      s_next.invalid  = 1'b0;
      s_next.notMedia = 1'b0;
      byteReady       = 1'b0;
      addrDone        = 1'b0;
      case (s_reg.st)
         mfod_pkg::ST_IDLE: begin
            byteReady = 1'b1;
            if (byteValid) begin
               if (byteData == mfod_pkg::ESC_BYTE) begin
                  s_next.st = mfod_pkg::ST_ESC;
               end else begin
                  s_next.notMedia = 1'b1;
               end
            end
         end
         mfod_pkg::ST_ESC: begin
            byteReady = 1'b1;
            if (byteValid) begin
               if (byteData == mfod_pkg::ESC_BYTE) begin
                  s_next.twoByte = 1'b1; // RULE_17
                  s_next.st      = mfod_pkg::ST_MODRM;
               end else if (byteData == mfod_pkg::OPC_EXIT) begin
                  // no modrm byte: issue straight away down the vector path
                  s_next.uopValid = 1'b1; // RULE_01
                  s_next.uopKind  = mfod_pkg::UOP_VECTOR;
                  s_next.uopOp    = mfod_pkg::OP_FAST_MEDIA_STATE_EXIT;
                  s_next.uopAddr  = mfod_pkg::RESET_ADDR;
                  s_next.modrm    = mfod_pkg::RESET_MODRM;
                  s_next.st       = mfod_pkg::ST_ISSUE;
               end else if (byteData == mfod_pkg::OPC_HINT) begin
                  s_next.twoByte = 1'b0;
                  s_next.st      = mfod_pkg::ST_MODRM;
               end else begin
                  s_next.notMedia = 1'b1;
                  s_next.st       = mfod_pkg::ST_IDLE;
               end
            end
         end
         mfod_pkg::ST_MODRM: begin
            byteReady = 1'b1;
            if (byteValid) begin
               s_next.modrm = byteData;
               // a hint needs a memory operand and reg field 000 or 001
               if (!s_reg.twoByte && (byteData[7:6] == mfod_pkg::MOD_REGISTER ||
                                      byteData[5:3] > mfod_pkg::REG_FETCHW)) begin
                  s_next.invalid = 1'b1;
                  s_next.st      = mfod_pkg::ST_IDLE;
               end else if (needsSib(byteData)) begin
                  s_next.st = mfod_pkg::ST_SIB;
               end else if (dispBytes(byteData) != mfod_pkg::RESET_DISP) begin
                  s_next.dispLeft = dispBytes(byteData);
                  s_next.st       = mfod_pkg::ST_DISP;
               end else begin
                  addrDone = 1'b1;
               end
            end
         end
         mfod_pkg::ST_SIB: begin
            byteReady = 1'b1;
            if (byteValid) begin
               if (sibDispBytes(s_reg.modrm, byteData) != mfod_pkg::RESET_DISP) begin
                  s_next.dispLeft = sibDispBytes(s_reg.modrm, byteData);
                  s_next.st       = mfod_pkg::ST_DISP;
               end else begin
                  addrDone = 1'b1;
               end
            end
         end
         mfod_pkg::ST_DISP: begin
            byteReady = 1'b1;
            if (byteValid) begin
               s_next.dispLeft = s_reg.dispLeft - 3'h1; // RULE_18
               if (s_reg.dispLeft == mfod_pkg::DISP8_BYTES) begin
                  addrDone = 1'b1;
               end
            end
         end
         mfod_pkg::ST_SUFFIX: begin
            byteReady = 1'b1;
            if (byteValid) begin
               if (!lk.known) begin
                  s_next.invalid = 1'b1; // RULE_19
                  s_next.st      = mfod_pkg::ST_IDLE;
               end else begin
                  s_next.uopValid = 1'b1;
                  s_next.uopOp    = lk.op;
                  s_next.st       = mfod_pkg::ST_ISSUE;
                  if (s_reg.modrm[7:6] == mfod_pkg::MOD_REGISTER) begin
                     s_next.uopKind = mfod_pkg::UOP_MEU; // RULE_16
                     s_next.uopAddr = mfod_pkg::RESET_ADDR;
                  end else begin
                     s_next.uopKind = mfod_pkg::UOP_MLOAD; // RULE_16
                     s_next.uopAddr = effAddr;
                  end
               end
            end
         end
         mfod_pkg::ST_ISSUE: begin
            // fetch is held off here, so a stalled execution unit stalls decode
            if (uopReady) begin
               if (s_reg.uopKind == mfod_pkg::UOP_MLOAD) begin
                  s_next.uopKind = mfod_pkg::UOP_MEU; // RULE_16
               end else begin
                  s_next.uopValid = 1'b0;
                  s_next.st       = mfod_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            s_next.st = mfod_pkg::ST_IDLE;
         end
      endcase
      if (addrDone) begin
         if (s_reg.twoByte) begin
            s_next.st = mfod_pkg::ST_SUFFIX; // RULE_18
         end else begin
            s_next.uopValid = 1'b1; // RULE_13
            s_next.uopKind  = mfod_pkg::UOP_LOAD;
            // the write hint has no separate behaviour, only its own tag
            s_next.uopOp    = (s_next.modrm[5:3] == mfod_pkg::REG_FETCH) ? mfod_pkg::OP_LINE_FETCH_HINT
                                                                         : mfod_pkg::OP_LINE_FETCH_WRITE_HINT; // RULE_14
            s_next.uopAddr  = effAddr & mfod_pkg::LINE_MASK; // RULE_15
            s_next.st       = mfod_pkg::ST_ISSUE;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '{st: mfod_pkg::ST_IDLE, twoByte: 1'b0, modrm: mfod_pkg::RESET_MODRM,
                    dispLeft: mfod_pkg::RESET_DISP, uopValid: 1'b0, uopKind: mfod_pkg::UOP_MEU,
                    uopOp: mfod_pkg::OP_NONE, uopAddr: mfod_pkg::RESET_ADDR, invalid: 1'b0,
                    notMedia: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign uopValid      = s_reg.uopValid;
   assign uopKind       = s_reg.uopKind;
   assign uopOp         = s_reg.uopOp;
   assign uopAddr       = s_reg.uopAddr;
   assign uopModrm      = s_reg.modrm;
   assign invalidOpcode = s_reg.invalid;
   assign notMedia      = s_reg.notMedia;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   logic sufTake;
   logic escTake;
   logic modrmTake;
   assign sufTake   = take && s_reg.st == mfod_pkg::ST_SUFFIX;
   assign escTake   = take && s_reg.st == mfod_pkg::ST_ESC;
   assign modrmTake = take && s_reg.st == mfod_pkg::ST_MODRM;

   sequence shortIssue(mfod_pkg::mfod_op_type o);
      uopValid && uopOp == o && uopKind != mfod_pkg::UOP_VECTOR && uopKind != mfod_pkg::UOP_LOAD;
   endsequence

   property suffixMaps(logic [7:0] code, mfod_pkg::mfod_op_type o);
      sufTake && byteData == code |=> shortIssue(o);
   endproperty

   sequence loadThenExec;
      (uopValid && uopKind == mfod_pkg::UOP_MLOAD && uopReady) ##1
      (uopValid && uopKind == mfod_pkg::UOP_MEU);
   endsequence

   exit_vector_a: assert property (escTake && byteData == mfod_pkg::OPC_EXIT |=> // RULE_01
      uopValid && uopKind == mfod_pkg::UOP_VECTOR && uopOp == mfod_pkg::OP_FAST_MEDIA_STATE_EXIT && !byteReady)
      else $error("fast exit not issued as vector operation");
   avg_map_a: assert property (suffixMaps(mfod_pkg::SFX_AVG, mfod_pkg::OP_PACKED_UBYTE_AVERAGE)) // RULE_02
      else $error("average opcode misdecoded");
   dword_conv_a: assert property (suffixMaps(mfod_pkg::SFX_I2FD, mfod_pkg::OP_DWORD_INT_TO_FLOAT)) // RULE_03
      else $error("dword conversion misdecoded");
   word_conv_a: assert property (suffixMaps(mfod_pkg::SFX_F2IW, mfod_pkg::OP_FLOAT_TO_WORD_INT)) // RULE_04
      else $error("word conversion misdecoded");
   accum_map_a: assert property (suffixMaps(mfod_pkg::SFX_PNACC, mfod_pkg::OP_FLOAT_MIXED_ACCUMULATE)) // RULE_05
      else $error("accumulate misdecoded");
   sub_map_a: assert property (suffixMaps(mfod_pkg::SFX_SUBR, mfod_pkg::OP_PACKED_FLOAT_REVERSE_SUBTRACT)) // RULE_06
      else $error("subtract misdecoded");
   cmp_map_a: assert property (suffixMaps(mfod_pkg::SFX_CMPGE, mfod_pkg::OP_FLOAT_COMPARE_GREATER_EQUAL)) // RULE_07
      else $error("compare misdecoded");
   minmax_map_a: assert property (suffixMaps(mfod_pkg::SFX_MIN, mfod_pkg::OP_PACKED_FLOAT_MINIMUM)) // RULE_08
      else $error("minimum misdecoded");
   mul_map_a: assert property (suffixMaps(mfod_pkg::SFX_MULHR, mfod_pkg::OP_WORD_MULTIPLY_HIGH_ROUNDED)) // RULE_09
      else $error("multiply-high misdecoded");
   rcp_map_a: assert property (suffixMaps(mfod_pkg::SFX_RCPIT2, mfod_pkg::OP_RECIPROCAL_REFINE_STEP2)) // RULE_10
      else $error("reciprocal step misdecoded");
   rsq_map_a: assert property (suffixMaps(mfod_pkg::SFX_RSQIT1, mfod_pkg::OP_INV_SQRT_REFINE_STEP1)) // RULE_11
      else $error("inverse sqrt step misdecoded");
   swap_map_a: assert property (suffixMaps(mfod_pkg::SFX_SWAP, mfod_pkg::OP_DWORD_HALF_SWAP)) // RULE_12
      else $error("half swap misdecoded");
   hint_load_a: assert property (uopValid && uopKind == mfod_pkg::UOP_LOAD |-> // RULE_13
      (uopOp == mfod_pkg::OP_LINE_FETCH_HINT || uopOp == mfod_pkg::OP_LINE_FETCH_WRITE_HINT) && !byteReady)
      else $error("load issued for something other than a hint");
   write_hint_a: assert property (modrmTake && !s_reg.twoByte && byteData[7:6] == mfod_pkg::MOD_NODISP && // RULE_14
      byteData[5:3] == mfod_pkg::REG_FETCHW && byteData[2:0] != mfod_pkg::RM_SIB &&
      byteData[2:0] != mfod_pkg::RM_DIRECT |=> uopValid && uopKind == mfod_pkg::UOP_LOAD)
      else $error("write hint not issued as a load");
   hint_line_a: assert property (uopValid && uopKind == mfod_pkg::UOP_LOAD |-> uopAddr[4:0] == 5'h00) // RULE_15
      else $error("hint address not line aligned");
   reg_form_a: assert property (sufTake && lk.known && s_reg.modrm[7:6] == mfod_pkg::MOD_REGISTER |=> // RULE_16
      uopValid && uopKind == mfod_pkg::UOP_MEU)
      else $error("register form did not issue a single execution operation");
   mem_pair_a: assert property (uopValid && uopKind == mfod_pkg::UOP_MLOAD && uopReady |-> // RULE_16
      loadThenExec and ##1 $stable(uopOp))
      else $error("memory load not followed by execution operation");
   escape_pair_a: assert property (escTake && byteData == mfod_pkg::ESC_BYTE |=> // RULE_17
      s_reg.st == mfod_pkg::ST_MODRM && s_reg.twoByte)
      else $error("double escape not taken into packed-float space");
   suffix_pos_a: assert property (take && s_reg.st == mfod_pkg::ST_DISP && s_reg.dispLeft == 3'h1 && // RULE_18
      s_reg.twoByte |=> s_reg.st == mfod_pkg::ST_SUFFIX)
      else $error("opcode byte not taken after displacement");
   invalid_op_a: assert property (sufTake && !lk.known |=> invalidOpcode && !uopValid ##1 !invalidOpcode) // RULE_19
      else $error("unknown opcode not flagged or issued anyway");
endmodule
`default_nettype wire

// File: mfod_pkg.sv
/*
 package for the media float opcode decoder: escape and opcode values, modrm field values,
 operation and micro-operation enumerations, decoder states.
 assumes nothing of its surroundings.
*/
`default_nettype none
package mfod_pkg;
   localparam logic [7:0]  ESC_BYTE      = 8'h0F;
   localparam logic [7:0]  OPC_EXIT      = 8'h0E;
   localparam logic [7:0]  OPC_HINT      = 8'h0D;
   localparam logic [7:0]  SFX_AVG       = 8'hBF;
   localparam logic [7:0]  SFX_F2ID      = 8'h1D;
   localparam logic [7:0]  SFX_I2FD      = 8'h0D;
   localparam logic [7:0]  SFX_F2IW      = 8'h1C;
   localparam logic [7:0]  SFX_I2FW      = 8'h0C;
   localparam logic [7:0]  SFX_ACC       = 8'hAE;
   localparam logic [7:0]  SFX_NACC      = 8'h8A;
   localparam logic [7:0]  SFX_PNACC     = 8'h8E;
   localparam logic [7:0]  SFX_ADD       = 8'h9E;
   localparam logic [7:0]  SFX_SUB       = 8'h9A;
   localparam logic [7:0]  SFX_SUBR      = 8'hAA;
   localparam logic [7:0]  SFX_CMPEQ     = 8'hB0;
   localparam logic [7:0]  SFX_CMPGE     = 8'h90;
   localparam logic [7:0]  SFX_CMPGT     = 8'hA0;
   localparam logic [7:0]  SFX_MAX       = 8'hA4;
   localparam logic [7:0]  SFX_MIN       = 8'h94;
   localparam logic [7:0]  SFX_MUL       = 8'hB4;
   localparam logic [7:0]  SFX_MULHR     = 8'hB7;
   localparam logic [7:0]  SFX_RCP       = 8'h96;
   localparam logic [7:0]  SFX_RCPIT1    = 8'hA6;
   localparam logic [7:0]  SFX_RCPIT2    = 8'hB6;
   localparam logic [7:0]  SFX_RSQRT     = 8'h97;
   localparam logic [7:0]  SFX_RSQIT1    = 8'hA7;
   localparam logic [7:0]  SFX_SWAP      = 8'hBB;
   localparam logic [1:0]  MOD_NODISP    = 2'h0;
   localparam logic [1:0]  MOD_DISP8     = 2'h1;
   localparam logic [1:0]  MOD_DISP32    = 2'h2;
   localparam logic [1:0]  MOD_REGISTER  = 2'h3;
   localparam logic [2:0]  RM_SIB        = 3'h4;
   localparam logic [2:0]  RM_DIRECT     = 3'h5;
   localparam logic [2:0]  REG_FETCH     = 3'h0;
   localparam logic [2:0]  REG_FETCHW    = 3'h1;
   localparam logic [2:0]  DISP8_BYTES   = 3'h1;
   localparam logic [2:0]  DISP32_BYTES  = 3'h4;
   localparam logic [31:0] LINE_MASK     = 32'hFFFFFFE0;
   localparam logic [31:0] RESET_ADDR    = 32'h00000000;
   localparam logic [7:0]  RESET_MODRM   = 8'h00;
   localparam logic [2:0]  RESET_DISP    = 3'h0;

   typedef enum logic [4:0] {
      OP_NONE, OP_FAST_MEDIA_STATE_EXIT, OP_LINE_FETCH_HINT, OP_LINE_FETCH_WRITE_HINT,
      OP_PACKED_UBYTE_AVERAGE, OP_FLOAT_TO_DWORD_INT, OP_DWORD_INT_TO_FLOAT, OP_FLOAT_TO_WORD_INT,
      OP_WORD_INT_TO_FLOAT, OP_FLOAT_ACCUMULATE, OP_FLOAT_NEG_ACCUMULATE, OP_FLOAT_MIXED_ACCUMULATE,
      OP_PACKED_FLOAT_ADD, OP_PACKED_FLOAT_SUBTRACT, OP_PACKED_FLOAT_REVERSE_SUBTRACT,
      OP_FLOAT_COMPARE_EQUAL, OP_FLOAT_COMPARE_GREATER_EQUAL, OP_FLOAT_COMPARE_GREATER,
      OP_PACKED_FLOAT_MAXIMUM, OP_PACKED_FLOAT_MINIMUM, OP_PACKED_FLOAT_MULTIPLY,
      OP_WORD_MULTIPLY_HIGH_ROUNDED, OP_RECIPROCAL_APPROX, OP_RECIPROCAL_REFINE_STEP1,
      OP_RECIPROCAL_REFINE_STEP2, OP_INV_SQRT_APPROX, OP_INV_SQRT_REFINE_STEP1, OP_DWORD_HALF_SWAP
   } mfod_op_type;

   typedef enum logic [1:0] {UOP_MEU, UOP_MLOAD, UOP_LOAD, UOP_VECTOR} mfod_uop_type;

   typedef enum logic [2:0] {ST_IDLE, ST_ESC, ST_MODRM, ST_SIB, ST_DISP, ST_SUFFIX, ST_ISSUE} mfod_state_type;
endpackage
`default_nettype wire

// File: mfod_lookup_if.sv
/*
 interface between the decoder sequencer and its opcode lookup.
 assumes mfod_pkg is compiled first.
*/
`default_nettype none
interface mfod_lookup_if;
   logic [7:0]            opcode;
   mfod_pkg::mfod_op_type op;
   logic                  known;
   modport lookup (input opcode, output op, output known);
   modport user   (output opcode, input op, input known);
endinterface
`default_nettype wire

// File: mfod_op_lookup.sv
/*
 opcode lookup for the two-byte-escape media space: maps the trailing opcode byte to an operation.
 assumes the sequencer presents the byte that follows the address bytes.
*/
`default_nettype none
module mfod_op_lookup (
   mfod_lookup_if.lookup port
);
   // every entry here is a short-decoded operation; anything else is unknown
   always_comb begin
      case (port.opcode)
         mfod_pkg::SFX_AVG:    port.op = mfod_pkg::OP_PACKED_UBYTE_AVERAGE;         // RULE_02
         mfod_pkg::SFX_F2ID:   port.op = mfod_pkg::OP_FLOAT_TO_DWORD_INT;           // RULE_03
         mfod_pkg::SFX_I2FD:   port.op = mfod_pkg::OP_DWORD_INT_TO_FLOAT;           // RULE_03
         mfod_pkg::SFX_F2IW:   port.op = mfod_pkg::OP_FLOAT_TO_WORD_INT;            // RULE_04
         mfod_pkg::SFX_I2FW:   port.op = mfod_pkg::OP_WORD_INT_TO_FLOAT;            // RULE_04
         mfod_pkg::SFX_ACC:    port.op = mfod_pkg::OP_FLOAT_ACCUMULATE;             // RULE_05
         mfod_pkg::SFX_NACC:   port.op = mfod_pkg::OP_FLOAT_NEG_ACCUMULATE;         // RULE_05
         mfod_pkg::SFX_PNACC:  port.op = mfod_pkg::OP_FLOAT_MIXED_ACCUMULATE;       // RULE_05
         mfod_pkg::SFX_ADD:    port.op = mfod_pkg::OP_PACKED_FLOAT_ADD;             // RULE_06
         mfod_pkg::SFX_SUB:    port.op = mfod_pkg::OP_PACKED_FLOAT_SUBTRACT;        // RULE_06
         mfod_pkg::SFX_SUBR:   port.op = mfod_pkg::OP_PACKED_FLOAT_REVERSE_SUBTRACT; // RULE_06
         mfod_pkg::SFX_CMPEQ:  port.op = mfod_pkg::OP_FLOAT_COMPARE_EQUAL;          // RULE_07
         mfod_pkg::SFX_CMPGE:  port.op = mfod_pkg::OP_FLOAT_COMPARE_GREATER_EQUAL;  // RULE_07
         mfod_pkg::SFX_CMPGT:  port.op = mfod_pkg::OP_FLOAT_COMPARE_GREATER;        // RULE_07
         mfod_pkg::SFX_MAX:    port.op = mfod_pkg::OP_PACKED_FLOAT_MAXIMUM;         // RULE_08
         mfod_pkg::SFX_MIN:    port.op = mfod_pkg::OP_PACKED_FLOAT_MINIMUM;         // RULE_08
         mfod_pkg::SFX_MUL:    port.op = mfod_pkg::OP_PACKED_FLOAT_MULTIPLY;        // RULE_09
         mfod_pkg::SFX_MULHR:  port.op = mfod_pkg::OP_WORD_MULTIPLY_HIGH_ROUNDED;   // RULE_09
         mfod_pkg::SFX_RCP:    port.op = mfod_pkg::OP_RECIPROCAL_APPROX;            // RULE_10
         mfod_pkg::SFX_RCPIT1: port.op = mfod_pkg::OP_RECIPROCAL_REFINE_STEP1;      // RULE_10
         mfod_pkg::SFX_RCPIT2: port.op = mfod_pkg::OP_RECIPROCAL_REFINE_STEP2;      // RULE_10
         mfod_pkg::SFX_RSQRT:  port.op = mfod_pkg::OP_INV_SQRT_APPROX;              // RULE_11
         mfod_pkg::SFX_RSQIT1: port.op = mfod_pkg::OP_INV_SQRT_REFINE_STEP1;        // RULE_11
         mfod_pkg::SFX_SWAP:   port.op = mfod_pkg::OP_DWORD_HALF_SWAP;              // RULE_12
         default:              port.op = mfod_pkg::OP_NONE;
      endcase
   end

   assign port.known = (port.op != mfod_pkg::OP_NONE); // RULE_19
endmodule
`default_nettype wire

// File: mfod_uop_sink.sv
/*
 partner model of the execution side: takes micro-operations from the decoder.
 assumes one clock shared with the decoder and its asynchronous active-low reset.
*/
`default_nettype none
module mfod_uop_sink (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic slow,
   input  wire logic uopValid,
   output logic      uopReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toggleReg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) toggleReg <= 1'h0;
      else toggleReg <= ~toggleReg;
   end
   // a slow sink is ready only on alternate cycles, so an offered uop must stand until taken
   assign uopReady = uopValid & (slow ? toggleReg : 1'h1);
endmodule
`default_nettype wire

// File: testbench.sv
/*
 self-checking bench for the media float opcode decoder with a uop sink partner.
 assumes mfod_pkg, the lookup interface and the design files are compiled first.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0, arst_n = 1'h0, byteValid = 1'h0, slow = 1'h0;
   logic [7:0]             byteData = 8'h00;
   logic [31:0]            effAddr = 32'h00000000;
   logic                   byteReady, uopValid, uopReady, invalidOpcode, notMedia;
   mfod_pkg::mfod_uop_type uopKind;
   mfod_pkg::mfod_op_type  uopOp;
   logic [31:0]            uopAddr;
   logic [7:0]             uopModrm;
   int n_fail = 0;
   int total_checks = 0;
   // suffixes in the order of their operations in the enumeration, from the average onward
   localparam logic [191:0] SFX_TABLE = 192'hBF1D0D1C0CAE8A8E9E9AAAB090A0A494B4B796A6B697A7BB;
   always #20 clk = ~clk;
   media_float_opcode_decoder DUT (.clk(clk), .arst_n(arst_n), .byteValid(byteValid), .byteData(byteData),
      .byteReady(byteReady), .effAddr(effAddr), .uopValid(uopValid), .uopReady(uopReady), .uopKind(uopKind),
      .uopOp(uopOp), .uopAddr(uopAddr), .uopModrm(uopModrm), .invalidOpcode(invalidOpcode), .notMedia(notMedia));
   mfod_uop_sink sink (.clk(clk), .arst_n(arst_n), .slow(slow), .uopValid(uopValid), .uopReady(uopReady));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bytes are right-aligned in s, first byte highest; valid stays up between bytes
   task automatic sendSeq(input logic [79:0] s, input int n);
      for (int j = 0; j < n; j++) begin
         byteData <= s[8*(n-1-j) +: 8];
         byteValid <= 1'h1;
         do @(posedge clk); while (byteReady !== 1'h1);
      end
      byteValid <= 1'h0;
   endtask
   task automatic expectUop(input mfod_pkg::mfod_uop_type k, input mfod_pkg::mfod_op_type o, input logic [31:0] a);
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (uopValid === 1'h1 && uopReady === 1'h1) break;
      end
      check("uopTaken", 32'(i < 20), 32'h1);
      check("uopKind", 32'(uopKind), 32'(k));
      check("uopOp", 32'(uopOp), 32'(o));
      check("uopAddr", uopAddr, a);
   endtask
   task automatic testRegForms;
      for (int i = 0; i < 24; i++) begin
         sendSeq({16'h0F0F, 8'hC1, SFX_TABLE[191-8*i -: 8]}, 4);
         expectUop(mfod_pkg::UOP_MEU, mfod_pkg::mfod_op_type'(i + 4), 32'h0);
         check("uopModrm", 32'(uopModrm), 32'hC1);
      end
      $display("test register forms done");
   endtask
   task automatic testMemForms;
      slow <= 1'h1;
      effAddr <= 32'h12345678;
      sendSeq(40'h0F0F4508B4, 5);
      expectUop(mfod_pkg::UOP_MLOAD, mfod_pkg::OP_PACKED_FLOAT_MULTIPLY, 32'h12345678);
      // the execution uop keeps the operand address of the load it follows
      expectUop(mfod_pkg::UOP_MEU, mfod_pkg::OP_PACKED_FLOAT_MULTIPLY, 32'h12345678);
      // sib with disp32; the unknown FF among the address bytes must not be taken as the opcode
      sendSeq(72'h0F0F0425FF0000009E, 9);
      expectUop(mfod_pkg::UOP_MLOAD, mfod_pkg::OP_PACKED_FLOAT_ADD, 32'h12345678);
      expectUop(mfod_pkg::UOP_MEU, mfod_pkg::OP_PACKED_FLOAT_ADD, 32'h12345678);
      slow <= 1'h0;
      $display("test memory forms done");
   endtask
   task automatic testHintsAndExit;
      effAddr <= 32'h0000ABCD;
      sendSeq(24'h0F0D08, 3);
      expectUop(mfod_pkg::UOP_LOAD, mfod_pkg::OP_LINE_FETCH_WRITE_HINT, 32'h0000ABC0);
      sendSeq(24'h0F0D00, 3);
      expectUop(mfod_pkg::UOP_LOAD, mfod_pkg::OP_LINE_FETCH_HINT, 32'h0000ABC0);
      sendSeq(16'h0F0E, 2);
      expectUop(mfod_pkg::UOP_VECTOR, mfod_pkg::OP_FAST_MEDIA_STATE_EXIT, 32'h0);
      check("uopModrm", 32'(uopModrm), 32'h0);
      $display("test hints and exit done");
   endtask
   task automatic testInvalid;
      sendSeq(32'h0F0FC100, 4);
      @(posedge clk);
      check("invalidOpcode", 32'(invalidOpcode), 32'h1);
      check("uopValid", 32'(uopValid), 32'h0);
      @(posedge clk);
      check("invalidOpcodeLow", 32'(invalidOpcode), 32'h0);
      check("uopValidLow", 32'(uopValid), 32'h0);
      $display("test invalid opcode done");
   endtask
   // a refused sequence gives a one-cycle flag pulse and never a uop
   task automatic expectFlags(input logic [79:0] s, input int n, input logic bad, input logic other);
      sendSeq(s, n);
      @(posedge clk);
      check("invalidOpcode", 32'(invalidOpcode), 32'(bad));
      check("notMedia", 32'(notMedia), 32'(other));
      check("uopValid", 32'(uopValid), 32'h0);
      @(posedge clk);
      check("flagsLow", 32'({invalidOpcode, notMedia}), 32'h0);
   endtask
   task automatic testRefused;
      expectFlags(8'h90, 1, 1'h0, 1'h1);
      expectFlags(16'h0F38, 2, 1'h0, 1'h1);
      expectFlags(24'h0F0DC0, 3, 1'h1, 1'h0);
      expectFlags(24'h0F0D10, 3, 1'h1, 1'h0);
      $display("test refused bytes done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'h1;
      testRegForms();
      testMemForms();
      testHintsAndExit();
      testInvalid();
      testRefused();
      final_report();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
